// ### logic/asbl_pkg.sv
package asbl_pkg;
    localparam int ASBL_ADDR_W = 18;
    localparam int ASBL_DATA_W = 16;
    localparam int ASBL_CLK_PERIOD_PS = 25000;
    // Access timings of the slower grade, in ns
    localparam int ASBL_T_RC_NS = 55;
    localparam int ASBL_T_AA_NS = 55;
    localparam int ASBL_T_HZ_NS = 18;
    localparam int ASBL_T_AW_NS = 40;
    localparam int ASBL_T_PWE_NS = 40;
    localparam int ASBL_T_SD_NS = 25;
    localparam int ASBL_T_HZWE_NS = 20;
    localparam int ASBL_T_WC_NS = 55;
    // Least times round up to whole cycles, never below one
    function automatic int asbl_cyc(input int ns);
        int c;
        c = (ns * 1000 + ASBL_CLK_PERIOD_PS - 1) / ASBL_CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    // Two extra edges: the data pin is seen through the two-flop synchroniser
    localparam int ASBL_RD_CYC = asbl_cyc(ASBL_T_AA_NS) + 2;
    localparam int ASBL_PW_NS = (ASBL_T_PWE_NS > ASBL_T_SD_NS + ASBL_T_HZWE_NS)
        ? ASBL_T_PWE_NS : ASBL_T_SD_NS + ASBL_T_HZWE_NS;
    localparam int ASBL_WR_CYC = asbl_cyc(ASBL_PW_NS);
    localparam int ASBL_REC_CYC = asbl_cyc(ASBL_T_HZ_NS);
    localparam int ASBL_CNT_W = 4;
    localparam logic [ASBL_CNT_W-1:0] ASBL_RD_CNT = ASBL_CNT_W'(ASBL_RD_CYC);
    localparam logic [ASBL_CNT_W-1:0] ASBL_WR_CNT = ASBL_CNT_W'(ASBL_WR_CYC);
    localparam logic [ASBL_CNT_W-1:0] ASBL_REC_CNT = ASBL_CNT_W'(ASBL_REC_CYC);
    typedef enum logic [1:0] {ASBL_IDLE, ASBL_READ, ASBL_WRITE, ASBL_RECOVER} asbl_state_e;
endpackage

// ### logic/asbl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asbl_sync
    import asbl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [ASBL_DATA_W-1:0] d_i,
    output logic [ASBL_DATA_W-1:0] q_o
);
    logic [ASBL_DATA_W-1:0] meta_r;
    logic [ASBL_DATA_W-1:0] meta_nxt;
    logic [ASBL_DATA_W-1:0] q_r;
    logic [ASBL_DATA_W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d_i;
        q_nxt = meta_r;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule
`default_nettype wire

// ### logic/asbl_host.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Write starts when strobe, selects, lanes active
// - Hold write data around terminating edge
// - Strobe pulse covers setup plus float time
// - Selects always driven at valid levels
module asbl_host
    import asbl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // User request side
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ASBL_ADDR_W-1:0] req_addr_i,
    input wire logic [ASBL_DATA_W-1:0] req_wdata_i,
    input wire logic [1:0] req_lanes_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [ASBL_DATA_W-1:0] rsp_rdata_o,
    // Memory pins
    output logic [ASBL_ADDR_W-1:0] mem_addr_o,
    output logic select_low_active_n_o,
    output logic select_high_active_o,
    output logic write_strobe_n_o,
    output logic output_enable_n_o,
    output logic upper_byte_lane_n_o,
    output logic lower_byte_lane_n_o,
    input wire logic [ASBL_DATA_W-1:0] mem_dq_i,
    output logic [ASBL_DATA_W-1:0] mem_dq_o,
    output logic mem_dq_oe_o
);
    asbl_state_e state_r, state_nxt;
    logic [ASBL_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [ASBL_ADDR_W-1:0] addr_r, addr_nxt;
    logic [ASBL_DATA_W-1:0] wdata_r, wdata_nxt;
    logic [1:0] lanes_r, lanes_nxt;
    logic sel_r, sel_nxt;
    logic we_r, we_nxt;
    logic oe_r, oe_nxt;
    logic drv_r, drv_nxt;
    logic rsp_r, rsp_nxt;
    logic [ASBL_DATA_W-1:0] rdata_r, rdata_nxt;
    logic [ASBL_DATA_W-1:0] dq_sync;
    wire logic [1:0] lane_n;

    // ****************************************
    // Data input synchroniser
    // ****************************************
    asbl_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i(mem_dq_i),
        .q_o(dq_sync)
    );

    // Keep only the lanes that were read; a floating lane reads zero
    function automatic logic [ASBL_DATA_W-1:0] lane_mask(input logic [1:0] lanes,
                                                         input logic [ASBL_DATA_W-1:0] d);
        lane_mask = {lanes[1] ? d[15:8] : 8'h00, lanes[0] ? d[7:0] : 8'h00};
    endfunction

    // ****************************************
    // Sequencer
    // ****************************************
    // Every access is a fixed count of cycles; no access overlaps the next
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        lanes_nxt = lanes_r;
        sel_nxt = sel_r;
        we_nxt = we_r;
        oe_nxt = oe_r;
        drv_nxt = drv_r;
        unique case (state_r)
            ASBL_IDLE: begin
                // A request with no lane would put the part in standby, so it is skipped
                if (req_valid_i && (req_lanes_i != 2'h0)) begin
                    addr_nxt = req_addr_i;
                    wdata_nxt = req_wdata_i;
                    lanes_nxt = req_lanes_i;
                    sel_nxt = 1'b1;
                    if (req_write_i) begin
                        // Strobe, selects and lanes open together; OE stays high
                        we_nxt = 1'b1;
                        drv_nxt = 1'b1;
                        cnt_nxt = ASBL_WR_CNT;
                        state_nxt = ASBL_WRITE;
                    end else begin
                        oe_nxt = 1'b1;
                        cnt_nxt = ASBL_RD_CNT;
                        state_nxt = ASBL_READ;
                    end
                end
            end
            ASBL_READ: begin
                // The count covers the access time plus the two synchroniser edges
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    sel_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    lanes_nxt = 2'h0;
                    cnt_nxt = ASBL_REC_CNT;
                    state_nxt = ASBL_RECOVER;
                end
            end
            ASBL_WRITE: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    // Strobe rises first; data, address and lanes held one more cycle
                    we_nxt = 1'b0;
                    cnt_nxt = ASBL_REC_CNT;
                    state_nxt = ASBL_RECOVER;
                end
            end
            ASBL_RECOVER: begin
                // One quiet cycle lets the part float its data before the next access
                sel_nxt = 1'b0;
                drv_nxt = 1'b0;
                lanes_nxt = 2'h0;
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    state_nxt = ASBL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_r <= ASBL_IDLE;
            cnt_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            lanes_r <= 2'h0;
            sel_r <= 1'b0;
            we_r <= 1'b0;
            oe_r <= 1'b0;
            drv_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            lanes_r <= lanes_nxt;
            sel_r <= sel_nxt;
            we_r <= we_nxt;
            oe_r <= oe_nxt;
            drv_r <= drv_nxt;
        end
    end

    // ****************************************
    // Response
    // ****************************************
    // The answer is given the cycle after the last count of an access. Read data crosses
    // the synchroniser, which costs two cycles but keeps a settling bus out of the logic
    always_comb begin
        rsp_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (cnt_r == 4'h1) begin
            unique case (state_r)
                ASBL_READ: begin
                    // Unread lanes float, so they are masked to zero
                    rdata_nxt = lane_mask(lanes_r, dq_sync);
                    rsp_nxt = 1'b1;
                end
                ASBL_WRITE: begin
                    rsp_nxt = 1'b1;
                end
                ASBL_IDLE, ASBL_RECOVER: begin
                    rsp_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rsp_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Both selects are always driven to full levels, never released
    assign select_low_active_n_o = ~sel_r;
    assign select_high_active_o = sel_r;
    assign write_strobe_n_o = ~we_r;
    assign output_enable_n_o = ~oe_r;
    // Each lane pin follows its request bit; a lane outside the access stays high
    for (genvar g = 0; g < 2; g++) begin : g_lane
        assign lane_n[g] = ~lanes_r[g];
    end
    assign upper_byte_lane_n_o = lane_n[1];
    assign lower_byte_lane_n_o = lane_n[0];
    // Address and write data come straight from flops, so they never glitch
    assign mem_addr_o = addr_r;
    assign mem_dq_o = wdata_r;
    assign mem_dq_oe_o = drv_r;
    assign req_ready_o = (state_r == ASBL_IDLE);
    assign rsp_valid_o = rsp_r;
    assign rsp_rdata_o = rdata_r;
endmodule
`default_nettype wire

// ### verification/asbl_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asbl_host_monitor (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_lanes_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic select_low_active_n_o,
    input wire logic select_high_active_o,
    input wire logic write_strobe_n_o,
    input wire logic output_enable_n_o,
    input wire logic upper_byte_lane_n_o,
    input wire logic lower_byte_lane_n_o,
    input wire logic mem_dq_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire tk = req_valid_i && req_ready_o && req_lanes_i != 2'h0;
    wire rd = tk && !req_write_i;
    wire [1:0] ln_n = {upper_byte_lane_n_o, lower_byte_lane_n_o};
    // ****
    // Pins
    // ****
    rd_latency_a: assert property (rd |-> ##6 rsp_valid_o) else $error("rd late");
    wr_pulse_a: assert property (tk && req_write_i |=>
        !write_strobe_n_o [*2] ##1 write_strobe_n_o) else $error("strobe");
    wr_overlap_a: assert property (!write_strobe_n_o |->
        !select_low_active_n_o && ln_n != 2'h3) else $error("overlap");
    sel_pair_a: assert property (select_low_active_n_o == !select_high_active_o)
        else $error("sel pair");
    end_hold_a: assert property ($rose(write_strobe_n_o) |->
        rsp_valid_o && mem_dq_oe_o && !select_low_active_n_o) else $error("hold");
    no_fight_a: assert property (mem_dq_oe_o |-> output_enable_n_o) else $error("fight");
    rd_lanes_a: assert property (rd |=>
        ln_n == ~$past(req_lanes_i) && !output_enable_n_o) else $error("lanes");
    idle_off_a: assert property (req_ready_o |->
        select_low_active_n_o && ln_n == 2'h3) else $error("idle");
    cover property (rd ##6 rsp_valid_o);
    cover property (tk && req_write_i);
    cover property (req_valid_i && req_lanes_i == 2'h0);
endmodule
bind asbl_host asbl_host_monitor asbl_host_monitor_i (.ref_clk_i, .srst_i, .req_valid_i,
    .req_write_i, .req_lanes_i, .req_ready_o, .rsp_valid_o, .select_low_active_n_o,
    .select_high_active_o, .write_strobe_n_o, .output_enable_n_o, .upper_byte_lane_n_o,
    .lower_byte_lane_n_o, .mem_dq_oe_o);
`default_nettype wire

// ### verification/asbl_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asbl_sram_model #(parameter int DLY = 55) (
    input wire logic [17:0] a_i,
    input wire logic sel_n_i,
    input wire logic sel_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic [1:0] ln_n_i,
    input wire logic [15:0] hd_i,
    input wire logic hoe_i,
    output logic [15:0] dq_o
);
    // ****
    // Storage
    // ****
    logic [15:0] mem [0:255];
    logic [15:0] flt = 16'h5A3C;
    logic [15:0] wd, wm, rdat;
    logic [7:0] wa;
    wire on = !sel_n_i && sel_i && ln_n_i != 2'h3;
    wire wr = on && !we_n_i;
    wire rde = on && we_n_i && !oe_n_i;
    wire rdy;
    // Read data turns good only an access time after the read opens
    assign #DLY rdy = rde;
    wire [15:0] dv = {{8{rde && rdy && !ln_n_i[1]}}, {8{rde && rdy && !ln_n_i[0]}}};
    // Released lines wander so a stale value never reads as good
    always #10 flt = ~flt;
    always @* if (wr) {wa, wm, wd} = {a_i[7:0], ~{{8{ln_n_i[1]}}, {8{ln_n_i[0]}}}, hd_i};
    always @(negedge wr) mem[wa] = (wm & wd) | (~wm & mem[wa]);
    assign #DLY rdat = mem[a_i[7:0]];
    assign dq_o = hoe_i ? hd_i : (dv & rdat) | (~dv & flt);
endmodule
`default_nettype wire

// ### verification/asbl_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asbl_host_tb;
    logic ref_clk_i = 1'b0, srst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic [17:0] req_addr_i = 18'h0, mem_addr_o;
    logic [15:0] req_wdata_i = 16'h0, rsp_rdata_o, mem_dq_o, mem_dq_i;
    logic [1:0] req_lanes_i = 2'h0;
    logic req_ready_o, rsp_valid_o, select_low_active_n_o, select_high_active_o;
    logic write_strobe_n_o, output_enable_n_o, upper_byte_lane_n_o, lower_byte_lane_n_o;
    logic mem_dq_oe_o;
    int err_total = 0, compares = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    asbl_host asbl_host_i (.ref_clk_i, .srst_i, .req_valid_i, .req_write_i, .req_addr_i,
        .req_wdata_i, .req_lanes_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .mem_addr_o,
        .select_low_active_n_o, .select_high_active_o, .write_strobe_n_o,
        .output_enable_n_o, .upper_byte_lane_n_o, .lower_byte_lane_n_o, .mem_dq_i,
        .mem_dq_o, .mem_dq_oe_o);
    asbl_sram_model #(.DLY(55)) asbl_sram_model_i (.a_i(mem_addr_o),
        .sel_n_i(select_low_active_n_o), .sel_i(select_high_active_o),
        .we_n_i(write_strobe_n_o), .oe_n_i(output_enable_n_o), .hd_i(mem_dq_o),
        .ln_n_i({upper_byte_lane_n_o, lower_byte_lane_n_o}), .hoe_i(mem_dq_oe_o),
        .dq_o(mem_dq_i));
    // ****
    // Tasks
    // ****
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Starts on a rising edge with the block idle, ends on one with it idle again
    task automatic xfer(input logic w, input logic [1:0] ln, input logic [15:0] d,
            input int lat, input logic [15:0] e);
        int n;
        n = 0;
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= 18'h2A5;
        req_wdata_i <= d;
        req_lanes_i <= ln;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        while (rsp_valid_o !== 1'b1 && n < 20) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("latency", 16'(lat), 16'(n));
        chk("addr lo", 16'h02A5, mem_addr_o[15:0]);
        chk("addr hi", 16'h0000, {14'h0000, mem_addr_o[17:16]});
        if (w)
            chk("wdata", d, mem_dq_o);
        if (!w)
            chk("rdata", e, rsp_rdata_o);
        while (req_ready_o !== 1'b1 && n < 40) begin
            @(negedge ref_clk_i);
            n++;
        end
        @(posedge ref_clk_i);
    endtask
    task automatic t_reset;
        @(negedge ref_clk_i);
        chk("idle pins", 16'h00DE, {req_ready_o, select_low_active_n_o,
            select_high_active_o, write_strobe_n_o, output_enable_n_o,
            upper_byte_lane_n_o, lower_byte_lane_n_o, mem_dq_oe_o});
        @(posedge ref_clk_i);
        $display("reset test done");
    endtask
    task automatic t_lanes;
        xfer(1'b1, 2'h3, 16'h1234, 3, 16'h0);
        xfer(1'b0, 2'h3, 16'h0, 6, 16'h1234);
        xfer(1'b1, 2'h1, 16'hFFAB, 3, 16'h0);
        xfer(1'b1, 2'h2, 16'hCDFF, 3, 16'h0);
        xfer(1'b0, 2'h1, 16'h0, 6, 16'h00AB);
        xfer(1'b0, 2'h2, 16'h0, 6, 16'hCD00);
        xfer(1'b0, 2'h3, 16'h0, 6, 16'hCDAB);
        $display("lane test done");
    endtask
    task automatic t_refuse;
        int n;
        n = 0;
        req_valid_i <= 1'b1;
        req_lanes_i <= 2'h0;
        repeat (6) begin
            @(negedge ref_clk_i);
            if (rsp_valid_o !== 1'b0 || req_ready_o !== 1'b1 || upper_byte_lane_n_o !== 1'b1)
                n++;
        end
        chk("refused", 16'h0, 16'(n));
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        @(posedge ref_clk_i);
        $display("refuse test done");
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset;
        t_lanes;
        t_refuse;
        tally_and_finish;
    end
    initial begin
        #20000;
        err_total++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
